// File: wfpf_top.sv
// Wake-up frame pattern filters with APB registers and interrupt.
`timescale 1ns/1ps
`include "wfpf_cfg.svh"

module wfpf_top #(
	parameter int NUM_FILT = 8
) (
	pclk,
	presetn,
	psel,
	penable,
	pwrite,
	paddr,
	pwdata,
	prdata,
	pready,
	pslverr,
	rx,
	wake,
	irq
);
	input  wire logic             pclk;
	input  wire logic             presetn;
	input  wire logic             psel;
	input  wire logic             penable;
	input  wire logic             pwrite;
	input  wire logic [11:0]      paddr;
	input  wire logic [31:0]      pwdata;
	output logic [31:0]           prdata;
	output logic                  pready;
	output logic                  pslverr;
	input  wfpf_pkg::wfpf_rx_t    rx;
	output logic                  wake;
	output logic                  irq;

	// ======================================================================
	// Elaboration check
	generate
		if (NUM_FILT < 1 || NUM_FILT > 8) begin : g_bad
			$error("NUM_FILT must lie between 1 and 8.");
		end
		if (8'hff + `WFPF_MASK_BYTES > `WFPF_CNT_MAX) begin : g_bad_cnt
			$error("Byte counter cannot reach the end of the widest window.");
		end
	endgenerate

	// ======================================================================
	// State
	typedef struct packed {
		wfpf_pkg::wfpf_filt_t [NUM_FILT-1:0] filt;
		logic [NUM_FILT-1:0][15:0]           crc;
		logic                                wake_frame_detect_enable;
		logic                                ucast_en;
		logic [`WFPF_IRQ_BITS-1:0]           stat;
		logic [`WFPF_IRQ_BITS-1:0]           mask;
		logic [NUM_FILT-1:0]                 match;
		logic [8:0]                          cnt;
		logic                                in_frame;
		logic                                bad;
		logic                                mcast;
		logic                                broadcast_reject;
		logic [31:0]                         rdata;
		logic                                wake;
	} wfpf_state_t;

	wfpf_state_t st_q;
	wfpf_state_t st_d;

	// ======================================================================
	// CRC step, one byte, least significant bit first as on the wire
	function automatic logic [15:0] wfpf_crc_byte(input logic [15:0] c,
		input logic [7:0] d);
		logic [15:0] r;
		logic        fb;
		r = c;
		for (int b = 0; b < 8; b++) begin
			fb = r[15] ^ d[b];
			r  = {r[14:0], 1'b0} ^ (fb ? `WFPF_CRC_POLY : 16'h0000);
		end
		return r;
	endfunction

	// ======================================================================
	// Bus decode
	logic        acc;
	logic        wr;
	logic        in_filt;
	logic [2:0]  fidx;
	logic [2:0]  fld;
	logic        mapped;

	always_comb begin
		acc     = psel && penable;
		wr      = acc && pwrite;
		in_filt = (paddr[11:8] == `WFPF_FILT_BASE);
		fidx    = paddr[7:5];
		fld     = paddr[4:2];
		mapped  = 1'b0;
		if (in_filt) begin
			mapped = (32'(fidx) < NUM_FILT) && (fld != 3'h7) && (paddr[1:0] == 2'h0);
		end else begin
			mapped = (paddr == `WFPF_CTRL_OFS) || (paddr == `WFPF_IRQ_STAT_OFS) ||
				(paddr == `WFPF_IRQ_MASK_OFS) || (paddr == `WFPF_MATCH_OFS);
		end
	end

	// ======================================================================
	// Read mux
	function automatic logic [31:0] wfpf_read(input wfpf_state_t s,
		input logic [11:0] a);
		logic [31:0]          r;
		wfpf_pkg::wfpf_filt_t f;
		r = 32'h0000_0000;
		f = s.filt[0];
		if (a[11:8] == `WFPF_FILT_BASE) begin
			if (32'(a[7:5]) < NUM_FILT) begin
				f = s.filt[a[7:5]];
				case (a[4:2])
					3'h0: r = f.mask[31:0];
					3'h1: r = f.mask[63:32];
					3'h2: r = f.mask[95:64];
					3'h3: r = f.mask[127:96];
					`WFPF_FLD_CMD: r = {28'h0000000, f.atype, 1'b0, f.enable};
					`WFPF_FLD_OFFSET: r = {24'h000000, f.offset};
					`WFPF_FLD_CRC: r = {16'h0000, f.crc};
					default: r = 32'h0000_0000;
				endcase
			end
		end else begin
			case (a)
				`WFPF_CTRL_OFS: begin
					r[`WFPF_CTRL_WAKE_FRAME_DETECT_ENABLE_BIT]  = s.wake_frame_detect_enable;
					r[`WFPF_CTRL_UCAST_BIT] = s.ucast_en;
				end
				`WFPF_IRQ_STAT_OFS: r[`WFPF_IRQ_BITS-1:0] = s.stat;
				`WFPF_IRQ_MASK_OFS: r[`WFPF_IRQ_BITS-1:0] = s.mask;
				`WFPF_MATCH_OFS: r[NUM_FILT-1:0] = s.match;
				default: r = 32'h0000_0000;
			endcase
		end
		return r;
	endfunction

	// ======================================================================
	// Frame classification of the byte on the stream
	logic       take;
	logic [8:0] pos;
	logic       frame_bc;
	logic       frame_mc;
	logic       frame_uc;
	logic       frame_bad;
	logic       always_ok;

	always_comb begin
		take      = rx.valid && (rx.sof || st_q.in_frame);
		pos       = rx.sof ? 9'h000 : st_q.cnt;
		frame_bad = (rx.sof ? 1'b0 : st_q.bad) || rx.err;
		frame_mc  = rx.sof ? rx.data[0] : st_q.mcast;
		frame_bc  = rx.sof ? 1'b1 : st_q.broadcast_reject;
		if (pos < 9'(`WFPF_DA_BYTES)) begin
			frame_bc = frame_bc && (rx.data == 8'hff);
		end
		frame_uc  = !frame_mc;
		// Broadcast and enabled unicast frames wake whatever the type field says.
		always_ok = frame_bc || (frame_uc && st_q.ucast_en);
	end

	// ======================================================================
	// Per-filter CRC machine and verdict
	logic [NUM_FILT-1:0][15:0] crc_nx;
	logic [NUM_FILT-1:0]       hits;

	generate
		for (genvar gi = 0; gi < NUM_FILT; gi++) begin : g_filt
			logic [8:0]  rel;
			logic [8:0]  start;
			logic [15:0] c;
			logic        in_win;
			logic        type_ok;
			logic        hit;

			// Bytes outside the window leave the running CRC untouched.
			always_comb begin
				start  = {1'b0, st_q.filt[gi].offset};
				rel    = pos - start;
				in_win = (pos >= start) && (rel < 9'(`WFPF_MASK_BYTES));
				c      = rx.sof ? `WFPF_CRC_INIT : st_q.crc[gi];
				if (in_win && st_q.filt[gi].mask[rel[6:0]]) begin
					c = wfpf_crc_byte(c, rx.data);
				end
				case (st_q.filt[gi].atype)
					wfpf_pkg::WFPF_AT_UCAST: begin
						type_ok = frame_uc && rx.addr_pass;
					end
					wfpf_pkg::WFPF_AT_MCAST: begin
						type_ok = frame_mc && !frame_bc && rx.addr_pass;
					end
					default: begin
						type_ok = rx.addr_pass;
					end
				endcase
				hit = st_q.filt[gi].enable && (c == st_q.filt[gi].crc) &&
					(always_ok || type_ok);
			end

			assign crc_nx[gi] = c;
			assign hits[gi]   = hit && rx.eof;
		end
	endgenerate

	// ======================================================================
	// Next state
	logic [`WFPF_IRQ_BITS-1:0] ev;
	logic                      any_hit;

	always_comb begin
		st_d      = st_q;
		ev        = '0;
		any_hit   = 1'b0;
		st_d.wake = 1'b0;

		// Receive side. A frame cut short by a new start is dropped with no verdict.
		if (take) begin
			st_d.crc = crc_nx;
			if (rx.eof) begin
				st_d.in_frame = 1'b0;
				any_hit = (|hits) && st_q.wake_frame_detect_enable && !frame_bad;
				// Filters that matched stay visible until the next wake frame.
				if (any_hit) begin
					st_d.match = hits;
				end
				st_d.wake = any_hit;
				ev[`WFPF_IRQ_WAKE_BIT] = any_hit;
				ev[`WFPF_IRQ_ERR_BIT]  = frame_bad;
			end else begin
				st_d.in_frame = 1'b1;
			end
			st_d.cnt   = (pos == `WFPF_CNT_MAX) ? pos : pos + 9'h001;
			st_d.bad   = frame_bad;
			st_d.broadcast_reject = frame_bc;
			st_d.mcast = frame_mc;
		end

		// Register side.
		// Read data is fetched in the setup cycle, so the access cycle needs no wait state.
		if (psel && !penable) begin
			st_d.rdata = wfpf_read(st_q, paddr);
		end
		if (wr && mapped) begin
			if (in_filt) begin
				case (fld)
					3'h0: st_d.filt[fidx].mask[31:0]   = pwdata;
					3'h1: st_d.filt[fidx].mask[63:32]  = pwdata;
					3'h2: st_d.filt[fidx].mask[95:64]  = pwdata;
					3'h3: st_d.filt[fidx].mask[127:96] = pwdata;
					`WFPF_FLD_CMD: begin
						st_d.filt[fidx].enable = pwdata[`WFPF_CMD_EN_BIT];
						st_d.filt[fidx].atype  = wfpf_pkg::wfpf_atype_t'(
							pwdata[`WFPF_CMD_TYPE_LSB +: 2]);
					end
					`WFPF_FLD_OFFSET: st_d.filt[fidx].offset = pwdata[7:0];
					`WFPF_FLD_CRC: st_d.filt[fidx].crc = pwdata[15:0];
					default: st_d.filt[fidx].crc = st_q.filt[fidx].crc;
				endcase
			end else begin
				case (paddr)
					`WFPF_CTRL_OFS: begin
						st_d.wake_frame_detect_enable     = pwdata[`WFPF_CTRL_WAKE_FRAME_DETECT_ENABLE_BIT];
						st_d.ucast_en = pwdata[`WFPF_CTRL_UCAST_BIT];
					end
					`WFPF_IRQ_STAT_OFS: st_d.stat = st_q.stat & ~pwdata[`WFPF_IRQ_BITS-1:0];
					`WFPF_IRQ_MASK_OFS: st_d.mask = pwdata[`WFPF_IRQ_BITS-1:0];
					default: st_d.mask = st_q.mask;
				endcase
			end
		end
		// A new event beats a clear in the same cycle.
		st_d.stat = st_d.stat | ev;
	end

	// ======================================================================
	// Registers
	// A flat reset leaves every filter disabled and wake detection off.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	// ======================================================================
	// Outputs
	assign prdata  = st_q.rdata;
	// Every access completes at once; an unmapped word answers with an error instead.
	assign pready  = 1'b1;
	assign pslverr = acc && !mapped;
	assign wake    = st_q.wake;
	// The interrupt is a level: software drops it by clearing the status bit.
	assign irq     = |(st_q.stat & st_q.mask);

endmodule

// File: wfpf_cfg.svh
// Register map, field positions, window sizes, counter limit and CRC settings of the wake filter block.
`ifndef WFPF_CFG_SVH
`define WFPF_CFG_SVH

// ==========================================================================
// Register offsets
`define WFPF_CTRL_OFS      12'h000
`define WFPF_IRQ_STAT_OFS  12'h004
`define WFPF_IRQ_MASK_OFS  12'h008
`define WFPF_MATCH_OFS     12'h00c
`define WFPF_FILT_BASE     4'h1
`define WFPF_FLD_CMD       3'h4
`define WFPF_FLD_OFFSET    3'h5
`define WFPF_FLD_CRC       3'h6

// ==========================================================================
// Field positions
`define WFPF_CTRL_WAKE_FRAME_DETECT_ENABLE_BIT 0
`define WFPF_CTRL_UCAST_BIT 9
`define WFPF_CMD_EN_BIT    0
`define WFPF_CMD_TYPE_LSB  2
`define WFPF_IRQ_WAKE_BIT  0
`define WFPF_IRQ_ERR_BIT   1
`define WFPF_IRQ_BITS      2

// ==========================================================================
// Window sizes, byte counter limit and CRC settings
`define WFPF_CRC_POLY      16'h8005
`define WFPF_CRC_INIT      16'hffff
`define WFPF_MASK_BYTES    128
`define WFPF_DA_BYTES      6
`define WFPF_CNT_MAX       9'h1ff

`endif

// File: wfpf_pkg.sv
// Types shared by the wake filter block and its users.
package wfpf_pkg;

	// ======================================================================
	// Receive byte stream from the MAC datapath
	typedef struct packed {
		logic       valid;
		logic       sof;
		logic       eof;
		logic       err;
		logic       addr_pass;
		logic [7:0] data;
	} wfpf_rx_t;

	// ======================================================================
	// Address type selector of a filter
	typedef enum logic [1:0] {
		WFPF_AT_UCAST = 2'h0,
		WFPF_AT_ANY   = 2'h1,
		WFPF_AT_MCAST = 2'h2,
		WFPF_AT_ANY2  = 2'h3
	} wfpf_atype_t;

	typedef struct packed {
		logic [127:0] mask;
		logic         enable;
		wfpf_atype_t  atype;
		logic [7:0]   offset;
		logic [15:0]  crc;
	} wfpf_filt_t;

endpackage

// File: wfpf_props.sv
// Port checker of the wake filter block.
`timescale 1ns/1ps
module wfpf_props #(
	parameter int NUM_FILT = 8
) (
	input wire logic              pclk,
	input wire logic              presetn,
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pwrite,
	input wire logic [11:0]       paddr,
	input wire logic [31:0]       pwdata,
	input wire logic [31:0]       prdata,
	input wire logic              pready,
	input wire logic              pslverr,
	input wire wfpf_pkg::wfpf_rx_t rx,
	input wire logic              wake,
	input wire logic              irq
);
	// ======================================
	// Properties
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic acc;
	logic filt;
	assign acc = psel && penable;
	assign filt = acc && paddr[11:8] == 4'h1;
	a_wake_single: assert property (wake |=> !wake)
		else $error("wake pulse too long");
	a_wake_after_eof: assert property (wake |-> $past(rx.valid && rx.eof))
		else $error("wake without frame end");
	a_err_no_wake: assert property (rx.valid && rx.eof && rx.err |=> !wake)
		else $error("errored frame woke");
	a_irq_rise_cause: assert property ($rose(irq) |->
		$past(rx.valid && rx.eof) || $past(acc && pwrite))
		else $error("irq rose without cause");
	a_irq_fall_write: assert property ($fell(irq) |->
		$past(acc && pwrite) || $past(acc && pwrite, 2))
		else $error("irq fell without write");
	a_mask_word_mapped: assert property (filt && !paddr[4] && paddr[1:0] == 2'h0 &&
		paddr[7:5] < NUM_FILT |-> !pslverr)
		else $error("mask word refused");
	a_gap_unmapped: assert property (filt && paddr[4:0] == 5'h1c |-> pslverr)
		else $error("gap word accepted");
	a_cmd_read_bits: assert property (filt && !pwrite && paddr[4:0] == 5'h10 |->
		prdata[31:4] == '0 && !prdata[1])
		else $error("command read has stray bits");
	a_stat_read_bits: assert property (acc && !pwrite && paddr == 12'h004 |-> prdata[31:2] == '0)
		else $error("status read has stray bits");
endmodule

bind wfpf_top wfpf_props #(.NUM_FILT(NUM_FILT)) u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .rx(rx), .wake(wake), .irq(irq));

// File: wfpf_mac_model.sv
// Receive stream model standing in for the MAC datapath.
`timescale 1ns/1ps
module wfpf_mac_model (
	input wire logic           pclk,
	output wfpf_pkg::wfpf_rx_t rx
);
	// ======================================
	// Frame sender
	initial rx = '0;
	task automatic send(input logic [127:0] f, input logic ap, input logic er);
		for (int k = 0; k < 16; k++) begin
			@(posedge pclk);
			rx.valid <= 1'b1;
			rx.sof <= (k == 0);
			rx.eof <= (k == 15);
			rx.err <= er && k > 6;
			rx.addr_pass <= ap && k == 15;
			rx.data <= f[8*k +: 8];
		end
		@(posedge pclk);
		// Idle data is inverted so a stale byte is never mistaken for live data.
		rx <= {5'h0, ~f[127:120]};
	endtask
endmodule

// File: wfpf_tb_top.sv
// Self-checking testbench of the wake filter block.
`timescale 1ns/1ps
module wfpf_tb_top;
	logic               pclk, presetn, psel, penable, pwrite, pready, pslverr, wake, irq, lerr;
	logic [11:0]        paddr;
	logic [31:0]        pwdata, prdata, rd;
	wfpf_pkg::wfpf_rx_t rx;
	int                 mismatches, num_checks, cyc, wakes, w0;
	logic [127:0]       fr;
	logic [9:0]         v;
	logic [15:0]        c;
	logic [9:0]         tc [10] = '{10'h184, 10'h004, 10'h0c4, 10'h1cc, 10'h0a8,
		10'h1e4, 10'h190, 10'h086, 10'h1c1, 10'h284};

	wfpf_top #(.NUM_FILT(8)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .rx(rx), .wake(wake), .irq(irq));
	wfpf_mac_model mac (.pclk(pclk), .rx(rx));

	// ======================================
	// Helpers
	initial begin
		pclk = 0;
		forever #25 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (wake === 1'b1) wakes <= wakes + 1;
		if (cyc == 5000) begin
			mismatches++;
			report_and_stop();
		end
	end
	function automatic logic [15:0] crc8(input logic [15:0] s, input logic [7:0] d);
		for (int b = 0; b < 8; b++) s = {s[14:0], 1'b0} ^ ((s[15] ^ d[b]) ? 16'h8005 : 16'h0);
		return s;
	endfunction
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		lerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic report_and_stop();
		$display("checks=%0d mismatches=%0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// ======================================
	// Sequence
	initial begin
		{psel, penable, pwrite, paddr, pwdata, presetn} = '0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		apb(0, 12'h110, 0);
		chk(rd, 0);
		apb(1, 12'h008, 1);
		apb(1, 12'h100, 32'h5);
		apb(1, 12'h114, 2);
		apb(0, 12'h100, 0);
		chk(rd, 32'h5);
		apb(0, 12'h114, 0);
		chk(rd, 32'h2);
		apb(0, 12'h11c, 0);
		chk({31'h0, lerr}, 32'h1);
		chk(rd, 32'h0);
		for (int i = 0; i < 10; i++) begin
			v = tc[i];
			for (int j = 0; j < 16; j++) begin
				fr[8*j +: 8] = (j > 5) ? 8'h40 + j[7:0] : v[4] ? 8'hff : (j == 0) ? {7'h1, v[3]}
					: 8'h30 + j[7:0];
			end
			// Only offset bytes 2 and 4 are masked in, so a wrong offset changes the sum.
			c = crc8(crc8(16'hffff, fr[23:16]), fr[39:32]) ^ {15'h0, v[9]};
			apb(1, 12'h110, 0);
			apb(1, 12'h118, {16'h0, c});
			apb(1, 12'h110, {28'h0, v[6:5], 1'b0, v[7]});
			apb(1, 12'h000, {22'h0, v[0], 9'h1});
			w0 = wakes;
			mac.send(fr, v[2], v[1]);
			repeat (3) @(posedge pclk);
			chk(wakes - w0, v[8]);
			chk(irq, v[8]);
			apb(0, 12'h004, 0);
			chk(rd, {30'h0, v[1], v[8]});
			apb(0, 12'h00c, 0);
			chk(rd, 32'h1);
			apb(0, 12'h000, 0);
			chk(rd, {22'h0, v[0], 9'h1});
			apb(1, 12'h004, 3);
			apb(0, 12'h004, 0);
			chk({rd[1:0], irq}, 0);
		end
		report_and_stop();
	end
endmodule
